// ===== rtl/sbat_map.svh
// Register map, field positions, reset values and counts of the arbiter timer.
// Assumes inclusion by bare name from every file that needs the constants.
`ifndef SBAT_MAP_SVH
`define SBAT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SBAT_OFS_CTRL 2'h0
`define SBAT_OFS_CNT_LOW 2'h1
`define SBAT_OFS_INT_STAT 2'h2
`define SBAT_OFS_INT_MASK 2'h3

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SBAT_CTL_MODE_HI 7
`define SBAT_CTL_MODE_LO 6
`define SBAT_CTL_LOST 5
`define SBAT_CTL_ACLK 4
`define SBAT_CTL_FIN 3
`define SBAT_CTL_RUN 2
`define SBAT_CTL_OVF 1
`define SBAT_CTL_MSB 0

// ----------------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------------
`define SBAT_INT_FIN 0
`define SBAT_INT_OVF 1
`define SBAT_INT_LOST 2
`define SBAT_INT_W 3

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define SBAT_RST_BYTE 8'h00
`define SBAT_RST_CNT 9'h000
`define SBAT_RST_INT 3'h0
`define SBAT_CNT_MAX 9'h1ff
`define SBAT_ARB_THR_BUS 9'h152
`define SBAT_ARB_THR_PRESC 9'h134
`define SBAT_DIV_LAST 2'h3
`define SBAT_DIV_RST 2'h0

`endif

// ===== rtl/sbat_pkg.sv
// Types shared by the arbiter timer and its surroundings.
// Assumes the map header is available on the include path.
package sbat_pkg;

  // --------------------------------------------------------------------------
  // Modes and states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBAT_MD_IDLE = 2'h0,
    SBAT_MD_MEAS = 2'h1,
    SBAT_MD_ARB = 2'h2,
    SBAT_MD_RSVD = 2'h3
  } sbat_mode_t;

  typedef enum logic [3:0] {
    SBAT_ST_IDLE = 4'h1,
    SBAT_ST_WAIT = 4'h2,
    SBAT_ST_RUN = 4'h4,
    SBAT_ST_HALT = 4'h8
  } sbat_state_t;

  // --------------------------------------------------------------------------
  // Register bus request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } sbat_req_t;

endpackage

// ===== rtl/sbat_top.sv
// Arbiter timer of the enhanced serial interface: bit time measurement and bus arbitration.
// Assumes one clock MCLK, a prescaler tick pulse synchronous to it, and a strobe-style register port.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "sbat_map.svh"

module sbat_top (
  input wire logic MCLK, // Bus clock.
  input wire logic RESET_N, // Asynchronous reset, active low.
  input wire sbat_pkg::sbat_req_t BUS_REQ, // Register strobes, address and write data.
  output logic [7:0] RDATA, // Read data, valid the cycle after a read.
  input wire logic RXD, // Receive line level.
  input wire logic TX_SHIFT_OUT, // Transmit shift register output.
  input wire logic PRESC_TICK, // One-cycle pulse per prescaler output clock.
  output logic TXD_OUT, // Transmit pin level.
  output logic IRQ // Interrupt request, active high level.
);
  import sbat_pkg::*;

  // --------------------------------------------------------------------------
  // State and decode
  // --------------------------------------------------------------------------
  sbat_mode_t mode_ff;
  logic aclk_ff;
  sbat_state_t st_ff;
  sbat_state_t nxt_st;
  logic [8:0] cnt_ff;
  logic fin_ff, ovf_ff, lost_ff;
  logic rx_low_seen_ff;
  logic rx_prev_ff;
  logic tx_prev_ff;
  logic [1:0] div_ff;
  logic half_ff;
  logic [`SBAT_INT_W-1:0] ist_ff;
  logic [`SBAT_INT_W-1:0] imask_ff;
  logic [`SBAT_INT_W-1:0] int_evt;
  logic wr_ctrl;
  logic tick;
  logic rx_fall, rx_rise, tx_rise, tx_fall;
  logic cnt_clr;
  logic cnt_step;
  logic ovf_evt;
  logic fin_set;
  logic lost_set;
  logic [8:0] arb_thr;
  logic [7:0] nxt_rdata;

  // Decodes a write strobe aimed at one register offset.
  function automatic logic wr_hit(input sbat_req_t req, input logic [1:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  // Strobes and line edges seen against the previous cycle.
  assign wr_ctrl = wr_hit(BUS_REQ, `SBAT_OFS_CTRL);
  assign rx_fall = rx_prev_ff && !RXD;
  assign rx_rise = !rx_prev_ff && RXD;
  assign tx_rise = !tx_prev_ff && TX_SHIFT_OUT;
  assign tx_fall = tx_prev_ff && !TX_SHIFT_OUT;

  // Line history for edge detection.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_prev_ff <= 1'b1;
      tx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= RXD;
      tx_prev_ff <= TX_SHIFT_OUT;
    end
  end

  // --------------------------------------------------------------------------
  // Counter clock
  // --------------------------------------------------------------------------
  // Dividers that turn the bus clock and the prescaler tick into count steps.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_ff <= `SBAT_DIV_RST;
      half_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      if (PRESC_TICK) begin
        half_ff <= !half_ff;
      end
    end
  end

  assign tick = aclk_ff ? (PRESC_TICK && half_ff) : (div_ff == `SBAT_DIV_LAST);

  // Sample point depends on the counter clock.
  assign arb_thr = aclk_ff ? `SBAT_ARB_THR_PRESC : `SBAT_ARB_THR_BUS;

  // --------------------------------------------------------------------------
  // Mode controller
  // --------------------------------------------------------------------------
  // Next state, counter clear and flag events; a control write overrides the state and forces a counter clear.
  always_comb begin
    nxt_st = st_ff;
    cnt_clr = 1'b0;
    fin_set = 1'b0;
    lost_set = 1'b0;
    unique case (st_ff)
      SBAT_ST_IDLE: begin
        cnt_clr = 1'b1;
      end
      SBAT_ST_WAIT: begin
        if (mode_ff == SBAT_MD_MEAS) begin
          if (aclk_ff ? !RXD : rx_fall) begin
            nxt_st = SBAT_ST_RUN;
          end
        end else if (tx_rise) begin
          cnt_clr = 1'b1;
          nxt_st = SBAT_ST_RUN;
        end
      end
      SBAT_ST_RUN: begin
        if (mode_ff == SBAT_MD_MEAS) begin
          if (aclk_ff ? rx_rise : rx_fall) begin
            nxt_st = SBAT_ST_HALT;
            fin_set = 1'b1;
          end
        end else if (tx_rise) begin
          cnt_clr = 1'b1;
        end else if (tx_fall && !rx_low_seen_ff) begin
          cnt_clr = 1'b1;
          nxt_st = SBAT_ST_WAIT;
        end else if (cnt_ff == arb_thr) begin
          lost_set = !RXD;
          nxt_st = SBAT_ST_HALT;
        end
      end
      SBAT_ST_HALT: begin
        if (mode_ff == SBAT_MD_ARB && tx_rise) begin
          cnt_clr = 1'b1;
          nxt_st = SBAT_ST_RUN;
        end
      end
    endcase
    if (wr_ctrl) begin
      cnt_clr = 1'b1;
      if (BUS_REQ.wdata[`SBAT_CTL_MODE_HI:`SBAT_CTL_MODE_LO] == SBAT_MD_MEAS ||
          BUS_REQ.wdata[`SBAT_CTL_MODE_HI:`SBAT_CTL_MODE_LO] == SBAT_MD_ARB) begin
        nxt_st = SBAT_ST_WAIT;
      end else begin
        nxt_st = SBAT_ST_IDLE;
      end
    end
  end

  // Count steps only while running and not stopping this cycle.
  assign cnt_step = (st_ff == SBAT_ST_RUN) && tick && (nxt_st == SBAT_ST_RUN) && !cnt_clr;
  assign ovf_evt = (st_ff == SBAT_ST_RUN) && tick && (cnt_ff == `SBAT_CNT_MAX) && !fin_set && !lost_set;

  // Controller state register.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= SBAT_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // nine-bit counter
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_ff <= `SBAT_RST_CNT;
    end else if (cnt_clr) begin
      cnt_ff <= `SBAT_RST_CNT;
    end else if (cnt_step) begin
      cnt_ff <= cnt_ff + 9'h001;
    end
  end

  // Remembers a receive low since the last arbitration restart.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_low_seen_ff <= 1'b0;
    end else if (cnt_clr) begin
      rx_low_seen_ff <= 1'b0;
    end else if (st_ff == SBAT_ST_RUN && !RXD) begin
      rx_low_seen_ff <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Control fields and flags
  // --------------------------------------------------------------------------
  // mode and clock select
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_ff <= SBAT_MD_IDLE;
      aclk_ff <= 1'b0;
    end else if (wr_ctrl) begin
      mode_ff <= sbat_mode_t'(BUS_REQ.wdata[`SBAT_CTL_MODE_HI:`SBAT_CTL_MODE_LO]);
      aclk_ff <= BUS_REQ.wdata[`SBAT_CTL_ACLK];
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fin_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      fin_ff <= fin_set || (fin_ff && !wr_ctrl);
      ovf_ff <= ovf_evt || (ovf_ff && !wr_ctrl);
    end
  end

  // lost flag clear by mode bit
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lost_ff <= 1'b0;
    end else begin
      lost_ff <= lost_set || (lost_ff && !(wr_ctrl && !BUS_REQ.wdata[`SBAT_CTL_MODE_HI]));
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TXD_OUT <= 1'b1;
    end else begin
      TXD_OUT <= lost_ff || lost_set || TX_SHIFT_OUT;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  assign int_evt = {lost_set, ovf_evt, fin_set};

  // Sticky status, cleared by writing ones; a new event wins over the clear.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ist_ff <= `SBAT_RST_INT;
      imask_ff <= `SBAT_RST_INT;
    end else begin
      if (wr_hit(BUS_REQ, `SBAT_OFS_INT_STAT)) begin
        ist_ff <= int_evt | (ist_ff & ~BUS_REQ.wdata[`SBAT_INT_W-1:0]);
      end else begin
        ist_ff <= int_evt | ist_ff;
      end
      if (wr_hit(BUS_REQ, `SBAT_OFS_INT_MASK)) begin
        imask_ff <= BUS_REQ.wdata[`SBAT_INT_W-1:0];
      end
    end
  end

  // Level interrupt from the unmasked status bits.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((int_evt | ist_ff) & imask_ff);
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // read multiplexer
  always_comb begin
    nxt_rdata = `SBAT_RST_BYTE;
    unique case (BUS_REQ.addr)
      `SBAT_OFS_CTRL: begin
        nxt_rdata[`SBAT_CTL_MODE_HI:`SBAT_CTL_MODE_LO] = mode_ff;
        nxt_rdata[`SBAT_CTL_LOST] = lost_ff;
        nxt_rdata[`SBAT_CTL_ACLK] = aclk_ff;
        nxt_rdata[`SBAT_CTL_FIN] = fin_ff;
        nxt_rdata[`SBAT_CTL_RUN] = (st_ff == SBAT_ST_RUN);
        nxt_rdata[`SBAT_CTL_OVF] = ovf_ff;
        nxt_rdata[`SBAT_CTL_MSB] = cnt_ff[8];
      end
      `SBAT_OFS_CNT_LOW: nxt_rdata = cnt_ff[7:0];
      `SBAT_OFS_INT_STAT: nxt_rdata[`SBAT_INT_W-1:0] = ist_ff;
      `SBAT_OFS_INT_MASK: nxt_rdata[`SBAT_INT_W-1:0] = imask_ff;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= `SBAT_RST_BYTE;
    end else if (BUS_REQ.rd) begin
      RDATA <= nxt_rdata;
    end else begin
      RDATA <= `SBAT_RST_BYTE;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_idle_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (mode_ff == SBAT_MD_IDLE && !wr_ctrl) |=> (cnt_ff == `SBAT_RST_CNT && st_ff == SBAT_ST_IDLE))
    else $error("Counter moved while idle.");
  a_write_clears: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (wr_ctrl && !fin_set && !ovf_evt) |=> (cnt_ff == `SBAT_RST_CNT && !fin_ff && !ovf_ff))
    else $error("Control write did not clear counter and flags.");
  a_lost_forces_tx: assert property (@(posedge MCLK) disable iff (!RESET_N)
    lost_ff |=> TXD_OUT)
    else $error("Transmit pin not forced high while lost.");
  a_lost_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (wr_ctrl && !BUS_REQ.wdata[`SBAT_CTL_MODE_HI] && !lost_set) |=> !lost_ff)
    else $error("Lost flag not cleared by mode write.");
  a_lost_sticky: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (lost_ff && !wr_ctrl) |=> lost_ff)
    else $error("Lost flag dropped without a write.");
  a_arb_restart: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (mode_ff == SBAT_MD_ARB && st_ff != SBAT_ST_IDLE && tx_rise && !wr_ctrl)
      |=> (cnt_ff == `SBAT_RST_CNT && st_ff == SBAT_ST_RUN))
    else $error("Transmit rise did not restart the counter.");
  a_arb_sample: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (mode_ff == SBAT_MD_ARB && st_ff == SBAT_ST_RUN && cnt_ff == arb_thr && !RXD && !tx_rise &&
     !(tx_fall && !rx_low_seen_ff)) |=> lost_ff)
    else $error("Low receive line at the sample point not flagged.");
  a_meas_stop: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (mode_ff == SBAT_MD_MEAS && !aclk_ff && st_ff == SBAT_ST_RUN && rx_fall && !wr_ctrl)
      |=> (fin_ff && st_ff == SBAT_ST_HALT) ##1 $stable(cnt_ff))
    else $error("Falling edge did not end the measurement.");
  a_break_start: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (mode_ff == SBAT_MD_MEAS && aclk_ff && st_ff == SBAT_ST_WAIT && !RXD && !wr_ctrl)
      |=> st_ff == SBAT_ST_RUN)
    else $error("Low receive line did not start the break count.");
  a_cnt_step: assert property (@(posedge MCLK) disable iff (!RESET_N)
    cnt_step |=> (cnt_ff == $past(cnt_ff) + 9'h001))
    else $error("Counter did not advance by one.");
  a_ovf_set: assert property (@(posedge MCLK) disable iff (!RESET_N)
    ovf_evt |=> (ovf_ff && (cnt_ff == `SBAT_RST_CNT || $past(wr_ctrl))))
    else $error("Counter wrap not flagged.");
  a_quarter_clk: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (!aclk_ff && tick) |=> ((div_ff != `SBAT_DIV_LAST) [*3] ##1 (div_ff == `SBAT_DIV_LAST)))
    else $error("Bus clock step not one in four.");

endmodule

// ===== tb/sbat_node.sv
// Far-side model: the other nodes sharing the single-wire serial bus.
// Assumes a wired-AND bus with a pull-up, so any dominant driver pulls it low.
`timescale 1ns/100ps

module sbat_node (
  input wire logic tx_level, // Level our transmit pin drives.
  input wire logic dom_req, // Far node drives the bus dominant.
  output logic bus_level // Resolved level seen on the receive line.
);
  // --------------------------------------------------------------------------
  // Bus resolution
  // --------------------------------------------------------------------------
  // The pull-up holds the bus recessive unless some node pulls it low.
  assign bus_level = tx_level & ~dom_req;
endmodule

// ===== tb/sbat_top_bench.sv
// Self-checking bench of the arbiter timer: registers, measurement, arbitration, interrupt.
// Assumes the map header on the include path and the far-node model beside it.
`timescale 1ns/100ps
`include "sbat_map.svh"

`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %s", $time, m); end end

module sbat_top_bench;
  import sbat_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic tx_shift = 1'b1;
  logic dom = 1'b0;
  logic tick = 1'b0;
  logic [1:0] tcnt = 2'h0;
  sbat_req_t req = '0;
  logic rxd, txd, irq;
  logic [7:0] rdata;
  int n_fail = 0;
  int checks = 0;

  // --------------------------------------------------------------------------
  // Clock, prescaler tick and instances
  // --------------------------------------------------------------------------
  // The 40 MHz bus clock.
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // One prescaler tick every four bus clocks.
  always @(posedge mclk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h2);
  end

  sbat_top u_sbat_top (.MCLK(mclk), .RESET_N(reset_n), .BUS_REQ(req), .RDATA(rdata), .RXD(rxd),
    .TX_SHIFT_OUT(tx_shift), .PRESC_TICK(tick), .TXD_OUT(txd), .IRQ(irq));
  sbat_node u_sbat_node (.tx_level(txd), .dom_req(dom), .bus_level(rxd));

  // --------------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------------
  // One write cycle, then the strobe drops.
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk) req <= {1'b1, 1'b0, a, d};
    @(posedge mclk) req <= '0;
  endtask

  // One read cycle; the data stand in the following cycle only.
  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk) req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) req <= '0;
    #1 d = rdata;
  endtask

  // Reads a register and compares the bits under a mask.
  task chk_rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    rd(a, d);
    `CHK(d & m, e, "register read")
  endtask

  task idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Polls the control register until a flag rises, within a bounded count.
  task poll(input int b);
    logic [7:0] d;
    for (int i = 0; i < 20; i++) begin
      rd(`SBAT_OFS_CTRL, d);
      if (d[b] === 1'b1) return;
    end
    n_fail++;
    $display("BAD %0t flag wait ran out", $time);
    results();
  endtask

  task results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_reset();
    chk_rd(`SBAT_OFS_CTRL, 8'h00, 8'hff);
    chk_rd(`SBAT_OFS_CNT_LOW, 8'h00, 8'hff);
    chk_rd(`SBAT_OFS_INT_STAT, 8'h00, 8'h07);
    chk_rd(`SBAT_OFS_INT_MASK, 8'h00, 8'h07);
    `CHK(txd, 1'b1, "transmit pin idle")
    `CHK(irq, 1'b0, "interrupt idle")
  endtask

  task t_fields();
    wr(`SBAT_OFS_CTRL, 8'h10);
    chk_rd(`SBAT_OFS_CTRL, 8'h10, 8'hff);
    wr(`SBAT_OFS_CTRL, 8'hd0);
    idle(40);
    chk_rd(`SBAT_OFS_CTRL, 8'hd0, 8'hff);
    chk_rd(`SBAT_OFS_CNT_LOW, 8'h00, 8'hff);
    wr(`SBAT_OFS_CTRL, 8'h2f);
    chk_rd(`SBAT_OFS_CTRL, 8'h00, 8'hff);
    wr(`SBAT_OFS_CNT_LOW, 8'h5a);
    idle(40);
    chk_rd(`SBAT_OFS_CNT_LOW, 8'h00, 8'hff);
  endtask

  // Fall to fall over 400 bus clocks gives about 100 counts at a quarter rate.
  task t_meas_fall();
    logic [7:0] d;
    wr(`SBAT_OFS_CTRL, 8'h40);
    idle(20);
    chk_rd(`SBAT_OFS_CTRL, 8'h40, 8'hff);
    @(posedge mclk) dom <= 1'b1;
    idle(100);
    chk_rd(`SBAT_OFS_CTRL, 8'h44, 8'hff);
    idle(98);
    dom <= 1'b0;
    idle(200);
    dom <= 1'b1;
    poll(`SBAT_CTL_FIN);
    chk_rd(`SBAT_OFS_CTRL, 8'h48, 8'hff);
    rd(`SBAT_OFS_CNT_LOW, d);
    `CHK(d >= 8'h63 && d <= 8'h65, 1'b1, "fall to fall count")
    idle(20);
    chk_rd(`SBAT_OFS_CNT_LOW, d, 8'hff);
    chk_rd(`SBAT_OFS_INT_STAT, 8'h01, 8'h07);
    `CHK(irq, 1'b0, "masked event")
    wr(`SBAT_OFS_INT_MASK, 8'h01);
    idle(2);
    #1 `CHK(irq, 1'b1, "unmasked event")
    wr(`SBAT_OFS_INT_STAT, 8'h01);
    idle(2);
    #1 `CHK(irq, 1'b0, "event cleared")
    wr(`SBAT_OFS_CTRL, 8'h00);
    chk_rd(`SBAT_OFS_CTRL, 8'h00, 8'hff);
    chk_rd(`SBAT_OFS_CNT_LOW, 8'h00, 8'hff);
    @(posedge mclk) dom <= 1'b0;
  endtask

  // The line is low at enable; 80 clocks low at eight clocks a count.
  task t_meas_low();
    logic [7:0] d;
    @(posedge mclk) dom <= 1'b1;
    wr(`SBAT_OFS_CTRL, 8'h50);
    idle(79);
    dom <= 1'b0;
    poll(`SBAT_CTL_FIN);
    chk_rd(`SBAT_OFS_CTRL, 8'h58, 8'hff);
    rd(`SBAT_OFS_CNT_LOW, d);
    `CHK(d >= 8'h09 && d <= 8'h0b, 1'b1, "low period count")
    wr(`SBAT_OFS_CTRL, 8'h00);
  endtask

  task t_ovf();
    wr(`SBAT_OFS_INT_STAT, 8'h07);
    wr(`SBAT_OFS_CTRL, 8'h40);
    @(posedge mclk) dom <= 1'b1;
    idle(1100);
    chk_rd(`SBAT_OFS_CTRL, 8'h45, 8'hff);
    idle(1000);
    chk_rd(`SBAT_OFS_CTRL, 8'h46, 8'hff);
    chk_rd(`SBAT_OFS_INT_STAT, 8'h02, 8'h07);
    wr(`SBAT_OFS_CTRL, 8'h00);
    chk_rd(`SBAT_OFS_CTRL, 8'h00, 8'hff);
    @(posedge mclk) dom <= 1'b0;
  endtask

  // Another node holds the bus dominant through the sample point.
  task t_arb_lost(input logic aclk, input int early, input int late);
    wr(`SBAT_OFS_INT_STAT, 8'h07);
    wr(`SBAT_OFS_INT_MASK, 8'h04);
    tx_shift <= 1'b0;
    dom <= 1'b1;
    wr(`SBAT_OFS_CTRL, {3'h4, aclk, 4'h0});
    @(posedge mclk) tx_shift <= 1'b1;
    idle(early);
    chk_rd(`SBAT_OFS_CTRL, 8'h00, 8'h20);
    idle(late - early);
    chk_rd(`SBAT_OFS_CTRL, 8'h20, 8'h20);
    `CHK(irq, 1'b1, "lost event")
    @(posedge mclk) tx_shift <= 1'b0;
    idle(3);
    #1 `CHK(txd, 1'b1, "pin forced high")
    wr(`SBAT_OFS_CTRL, {3'h4, aclk, 4'h0});
    chk_rd(`SBAT_OFS_CTRL, 8'h20, 8'h20);
    wr(`SBAT_OFS_CTRL, 8'h00);
    idle(2);
    chk_rd(`SBAT_OFS_CTRL, 8'h00, 8'h20);
    `CHK(txd, 1'b0, "pin follows shift output")
    @(posedge mclk) dom <= 1'b0;
    tx_shift <= 1'b1;
    wr(`SBAT_OFS_INT_STAT, 8'h07);
  endtask

  task t_arb_restart();
    logic [7:0] d;
    tx_shift <= 1'b0;
    wr(`SBAT_OFS_CTRL, 8'h80);
    @(posedge mclk) tx_shift <= 1'b1;
    idle(100);
    rd(`SBAT_OFS_CNT_LOW, d);
    `CHK(d > 8'h10, 1'b1, "counting after rise")
    @(posedge mclk) tx_shift <= 1'b0;
    idle(8);
    chk_rd(`SBAT_OFS_CTRL, 8'h80, 8'hff);
    chk_rd(`SBAT_OFS_CNT_LOW, 8'h00, 8'hff);
    @(posedge mclk) tx_shift <= 1'b1;
    idle(40);
    chk_rd(`SBAT_OFS_CTRL, 8'h84, 8'hff);
    idle(1400);
    chk_rd(`SBAT_OFS_CTRL, 8'h80, 8'ha4);
    wr(`SBAT_OFS_CTRL, 8'h00);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    idle(2);
    reset_n <= 1'b1;
    t_reset();
    t_fields();
    t_meas_fall();
    t_meas_low();
    t_ovf();
    t_arb_lost(1'b0, 1300, 1420);
    t_arb_lost(1'b1, 2400, 2520);
    t_arb_restart();
    results();
  end

  // Cuts a hang short and reports it as a mismatch.
  initial begin
    #2000000;
    n_fail++;
    results();
  end
endmodule
